// ---- shared/rofs_pkg.sv ----
// Package for the relay output function selector: function codes and sizes.
// Assumes nothing beyond a SystemVerilog compiler.
package rofs_pkg;
  localparam int RELAY_COUNT = 5;
  localparam int FUNC_WIDTH = 6;
  localparam int COND_COUNT = 14;
  localparam logic [5:0] FUNC_BYPASS_OVERLOAD = 6'h13;
  localparam logic [5:0] FUNC_BYPASS_UNDERLOAD = 6'h14;
  localparam logic [5:0] FUNC_BOARD_OVERTEMP = 6'h15;
  localparam logic [5:0] FUNC_SYSTEM_UNDERLOAD = 6'h16;
  localparam logic [5:0] FUNC_SYSTEM_FAULT = 6'h17;
  localparam logic [5:0] FUNC_SYSTEM_FAULT_OR_WARNING = 6'h18;
  localparam logic [5:0] FUNC_AUTO_CONTROL = 6'h19;
  localparam logic [5:0] FUNC_SYSTEM_OVERLOAD = 6'h1a;
  localparam logic [5:0] FUNC_CONTACTOR_FAULT = 6'h1b;
  localparam logic [5:0] FUNC_SYSTEM_HEALTHY = 6'h1c;
  localparam logic [5:0] FUNC_INTERNAL_LINK_ERROR = 6'h1d;
  localparam logic [5:0] FUNC_NETWORK_LOSS = 6'h1e;
  localparam logic [5:0] FUNC_OVERRIDE_TWO_STOP = 6'h1f;
  localparam logic [5:0] FUNC_OVERRIDE_TWO_ENABLE = 6'h20;
  localparam logic [5:0] FUNC_FIRST = FUNC_BYPASS_OVERLOAD;
  localparam logic [5:0] FUNC_RESET = 6'h00;
  localparam logic [7:0] TEMP_LIMIT = 8'h55;
  localparam int INTERLOCK_COUNT = 6;
endpackage

// ---- shared/rofs_cond_if.sv ----
// Interface carrying the condition vector from the evaluator to the relay stage.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface rofs_cond_if;
  logic [13:0] cond;
  modport src (output cond);
  modport dst (input cond);
endinterface

// ---- rtl/rofs_relay_mux.sv ----
// Per-relay function multiplexer: picks one condition per relay, registered.
// Assumes conditions are already synchronised to clk.
`timescale 1ns/1ps
module rofs_relay_mux #(
  parameter int RELAYS = 5
) (
  input wire logic clk,
  input wire logic resetn,
  rofs_cond_if.dst cond_in,
  input wire logic [RELAYS*6-1:0] func_sel,
  output logic [RELAYS-1:0] coil
);
  import rofs_pkg::*;
  typedef struct packed {
    logic [RELAYS-1:0] coil;
  } rofs_mux_state_type;
  rofs_mux_state_type state_r;
  rofs_mux_state_type state_nxt;
  if (RELAYS < 1) begin : g_relays_check
    $error("RELAYS must be at least one.");
  end
  always_comb begin
    logic [5:0] code;
    logic [5:0] idx;
    code = 6'h00;
    idx = 6'h00;
    state_nxt = state_r;
    for (int i = 0; i < RELAYS; i++) begin
      code = func_sel[i*6 +: 6];
      idx = 6'(code - FUNC_FIRST);
      // Codes outside the supported range leave the coil released.
      if (code >= FUNC_FIRST && code <= FUNC_OVERRIDE_TWO_ENABLE) begin
        state_nxt.coil[i] = cond_in.cond[idx[3:0]];
      end else begin
        state_nxt.coil[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end
  assign coil = state_r.coil;
endmodule // rofs_relay_mux

// ---- rtl/rofs_top.sv ----
// Relay output function selector: evaluates status conditions and drives relays.
// Assumes status flags come from other clock domains or pins and are synchronised here; levels and board temperature share clk.
`timescale 1ns/1ps

// Overview of operation
// - Function 19: bypass overload above threshold.
// - Function 20: bypass underload below threshold.
// - Function 21: board temperature above fixed limit.
// - Function 22: drive or bypass underload.
// - Function 23: any fault or bypass trip.
// - Function 24: fault, bypass trip, or warning.
// - Function 25: selected source mode is Auto.
// - Function 26: drive or bypass overload.
// - Function 27: either contactor fault.
// - Function 28: healthy unless any fault or a trip of the selected source.
// - Function 29: internal drive link interrupted.
// - Function 30: building network communication lost.
// - Function 31: override two active, action stop.
// - Function 32: contactor closed, acknowledged interlocks present.

module rofs_top #(
  parameter int RELAYS = 5
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [RELAYS*rofs_pkg::FUNC_WIDTH-1:0] func_sel,
  input wire logic [15:0] bypass_overload_level,
  input wire logic [15:0] bypass_overload_limit,
  input wire logic [15:0] bypass_underload_level,
  input wire logic [15:0] bypass_underload_limit,
  input wire logic [15:0] drive_overload_level,
  input wire logic [15:0] drive_overload_limit,
  input wire logic [15:0] drive_underload_level,
  input wire logic [15:0] drive_underload_limit,
  input wire logic [7:0] board_temp,
  input wire logic drive_fault,
  input wire logic bypass_fault,
  input wire logic drive_warning,
  input wire logic bypass_warning,
  input wire logic bypass_selected,
  input wire logic drive_auto,
  input wire logic bypass_auto,
  input wire logic drive_contactor_fault,
  input wire logic bypass_contactor_fault,
  input wire logic drive_contactor_closed,
  input wire logic internal_link_lost,
  input wire logic network_link_lost,
  input wire logic override_two_active,
  input wire logic override_two_action_stop,
  input wire logic [rofs_pkg::INTERLOCK_COUNT-1:0] interlock_ack_cfg,
  input wire logic [rofs_pkg::INTERLOCK_COUNT-1:0] interlock_present,
  output logic [RELAYS-1:0] relay_coil,
  output logic [rofs_pkg::COND_COUNT-1:0] condition_status
);
  import rofs_pkg::*;

  // Flags that arrive from other domains; each passes two flip-flops before use.
  typedef struct packed {
    logic drive_fault;
    logic bypass_fault;
    logic drive_warning;
    logic bypass_warning;
    logic bypass_selected;
    logic drive_auto;
    logic bypass_auto;
    logic drive_contactor_fault;
    logic bypass_contactor_fault;
    logic drive_contactor_closed;
    logic internal_link_lost;
    logic network_link_lost;
    logic override_two_active;
    logic override_two_action_stop;
    logic [INTERLOCK_COUNT-1:0] interlock_ack_cfg;
    logic [INTERLOCK_COUNT-1:0] interlock_present;
  } rofs_flags_type;

  typedef struct packed {
    rofs_flags_type sync1;
    rofs_flags_type sync2;
    logic [COND_COUNT-1:0] cond;
  } rofs_top_state_type;

  rofs_top_state_type state_r;
  rofs_top_state_type state_nxt;
  rofs_flags_type raw_in;
  rofs_flags_type s;
  rofs_cond_if cond_bus();

  logic byp_ovl;
  logic byp_unl;
  logic drv_ovl;
  logic drv_unl;
  logic over_temp;

  logic any_fault;
  logic any_warn;
  logic active_trip;
  logic interlocks_ok;

  logic bypass_overload_out;
  logic bypass_underload_out;
  logic board_overtemp_out;
  logic system_underload_out;
  logic system_fault_out;
  logic system_fault_or_warning_out;
  logic auto_control_out;
  logic system_overload_out;
  logic contactor_fault_out;
  logic system_healthy_out;
  logic internal_link_error_out;
  logic network_loss_out;
  logic override_two_stop_out;
  logic override_two_enable_out;

  // The relay stage indexes six-bit codes and expects one condition per function.
  if (RELAYS < 1 || RELAYS > 16) begin : g_relays_check
    $error("RELAYS must lie between one and sixteen.");
  end
  if (FUNC_WIDTH != 6) begin : g_width_check
    $error("Function codes must be six bits wide.");
  end
  if (COND_COUNT != int'(FUNC_OVERRIDE_TWO_ENABLE - FUNC_FIRST) + 1) begin : g_cond_check
    $error("The condition vector must hold one bit per function.");
  end
  if (INTERLOCK_COUNT < 1) begin : g_interlock_check
    $error("At least one interlock input is needed.");
  end

  // Gathers the asynchronous flags into the first synchroniser stage.
  always_comb begin
    raw_in.drive_fault = drive_fault;
    raw_in.bypass_fault = bypass_fault;
    raw_in.drive_warning = drive_warning;
    raw_in.bypass_warning = bypass_warning;
    raw_in.bypass_selected = bypass_selected;
    raw_in.drive_auto = drive_auto;
    raw_in.bypass_auto = bypass_auto;
    raw_in.drive_contactor_fault = drive_contactor_fault;
    raw_in.bypass_contactor_fault = bypass_contactor_fault;
    raw_in.drive_contactor_closed = drive_contactor_closed;
    raw_in.internal_link_lost = internal_link_lost;
    raw_in.network_link_lost = network_link_lost;
    raw_in.override_two_active = override_two_active;
    raw_in.override_two_action_stop = override_two_action_stop;
    raw_in.interlock_ack_cfg = interlock_ack_cfg;
    raw_in.interlock_present = interlock_present;
  end

  assign s = state_r.sync2;

  // Level comparisons use same-clock values, so they skip the synchroniser.
  assign byp_ovl = bypass_overload_level > bypass_overload_limit;
  assign byp_unl = bypass_underload_level < bypass_underload_limit;
  assign drv_ovl = drive_overload_level > drive_overload_limit;
  assign drv_unl = drive_underload_level < drive_underload_limit;
  assign over_temp = board_temp > TEMP_LIMIT;

  assign any_fault = s.drive_fault | s.bypass_fault;
  assign any_warn = s.drive_warning | s.bypass_warning;
  // The active protection belongs to the selected power source.
  assign active_trip = s.bypass_selected ? (byp_ovl | byp_unl) : (drv_ovl | drv_unl);
  assign interlocks_ok = (s.interlock_ack_cfg & ~s.interlock_present) == '0;

  // One term per relay function, in code order from the first function.
  assign bypass_overload_out = byp_ovl;
  assign bypass_underload_out = byp_unl;
  assign board_overtemp_out = over_temp;
  assign system_underload_out = drv_unl | byp_unl;
  assign system_fault_out = any_fault | byp_ovl | byp_unl;
  assign system_fault_or_warning_out = any_fault | byp_ovl | byp_unl | any_warn;
  assign auto_control_out = s.bypass_selected ? s.bypass_auto : s.drive_auto;
  assign system_overload_out = drv_ovl | byp_ovl;
  assign contactor_fault_out = s.drive_contactor_fault | s.bypass_contactor_fault;
  assign system_healthy_out = ~(any_fault | active_trip);
  assign internal_link_error_out = s.internal_link_lost;
  assign network_loss_out = s.network_link_lost;
  assign override_two_stop_out = s.override_two_active & s.override_two_action_stop;
  assign override_two_enable_out = s.drive_contactor_closed & interlocks_ok;

  // Only the second synchroniser stage feeds logic.
  always_comb begin
    state_nxt = state_r;
    state_nxt.sync1 = raw_in;
    state_nxt.sync2 = state_r.sync1;
    state_nxt.cond[0] = bypass_overload_out;
    state_nxt.cond[1] = bypass_underload_out;
    state_nxt.cond[2] = board_overtemp_out;
    state_nxt.cond[3] = system_underload_out;
    state_nxt.cond[4] = system_fault_out;
    state_nxt.cond[5] = system_fault_or_warning_out;
    state_nxt.cond[6] = auto_control_out;
    state_nxt.cond[7] = system_overload_out;
    state_nxt.cond[8] = contactor_fault_out;
    state_nxt.cond[9] = system_healthy_out;
    state_nxt.cond[10] = internal_link_error_out;
    state_nxt.cond[11] = network_loss_out;
    state_nxt.cond[12] = override_two_stop_out;
    state_nxt.cond[13] = override_two_enable_out;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cond_bus.cond = state_r.cond;
  assign condition_status = state_r.cond;

  // The relay stage picks one registered condition per relay.
  rofs_relay_mux #(.RELAYS(RELAYS)) u_mux (
    .clk(clk),
    .resetn(resetn),
    .cond_in(cond_bus.dst),
    .func_sel(func_sel),
    .coil(relay_coil)
  );
endmodule // rofs_top

// ---- verif/rofs_top_assertions.sv ----
// Timing checks on the relay selector ports.
// Assumes it is bound into rofs_top.
`timescale 1ns/1ps
module rofs_top_assertions import rofs_pkg::*; #(
  parameter int RELAYS = 5
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [RELAYS*6-1:0] func_sel,
  input wire logic [15:0] bypass_overload_level,
  input wire logic [15:0] bypass_overload_limit,
  input wire logic [7:0] board_temp,
  input wire logic internal_link_lost,
  input wire logic network_link_lost,
  input wire logic override_two_active,
  input wire logic override_two_action_stop,
  input wire logic drive_contactor_fault,
  input wire logic bypass_contactor_fault,
  input wire logic [RELAYS-1:0] relay_coil,
  input wire logic [13:0] condition_status
);
  logic [2:0] up_r;
  logic sel_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_r <= 3'h0;
      sel_r <= 1'b0;
    end else begin
      up_r <= (up_r == 3'h7) ? up_r : up_r + 3'h1;
      sel_r <= (func_sel[5:0] inside {[6'h13:6'h20]}) ? condition_status[func_sel[5:0] - 6'h13] : 1'b0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_byp_over: assert property (up_r[2] |->
    condition_status[0] == ($past(bypass_overload_level) > $past(bypass_overload_limit))) else $error("byp over");
  chk_board_temp: assert property (up_r[2] |-> condition_status[2] == ($past(board_temp) > TEMP_LIMIT))
    else $error("board temp");
  chk_trip_fault: assert property (up_r[2] && $past(bypass_overload_level) > $past(bypass_overload_limit) |->
    condition_status[5:4] == 2'h3) else $error("trip fault");
  chk_contactor_fault: assert property (up_r[2] |->
    condition_status[8] == ($past(drive_contactor_fault, 3) | $past(bypass_contactor_fault, 3))) else $error("contactor");
  chk_link_err: assert property (up_r[2] |-> condition_status[10] == $past(internal_link_lost, 3))
    else $error("link error");
  chk_net_loss: assert property (up_r[2] |-> condition_status[11] == $past(network_link_lost, 3))
    else $error("net loss");
  chk_ovr_stop: assert property (up_r[2] |->
    condition_status[12] == ($past(override_two_active, 3) & $past(override_two_action_stop, 3))) else $error("ovr stop");
  chk_coil_sel: assert property (up_r[2] |-> relay_coil[0] == sel_r)
    else $error("coil select");
endmodule // rofs_top_assertions

// ---- verif/rofs_relay_load.sv ----
// Relay load: contacts follow coils.
// Assumes ideal contacts.
`timescale 1ns/1ps
module rofs_relay_load #(
  parameter int RELAYS = 5
) (
  input wire logic [RELAYS-1:0] coil,
  output logic [RELAYS-1:0] contact
);
  assign contact = coil;
endmodule // rofs_relay_load

// ---- verif/relay_output_function_select_tb.sv ----
// Bench with a steady-state model of every function.
// Assumes the checker and load are compiled first.
`timescale 1ns/1ps
module relay_output_function_select_tb;
  import rofs_pkg::*;
  logic clk = 0, resetn = 0, drive_fault, bypass_fault, drive_warning, bypass_warning, bypass_selected, drive_auto;
  logic bypass_auto, drive_contactor_fault, bypass_contactor_fault, drive_contactor_closed, internal_link_lost;
  logic network_link_lost, override_two_active, override_two_action_stop;
  logic [15:0] bypass_overload_level, bypass_overload_limit, bypass_underload_level, bypass_underload_limit;
  logic [15:0] drive_overload_level, drive_overload_limit, drive_underload_level, drive_underload_limit;
  logic [29:0] func_sel;
  logic [7:0] board_temp;
  logic [5:0] interlock_ack_cfg, interlock_present;
  logic [4:0] relay_coil, contact;
  logic [13:0] condition_status, exp;
  logic bo, bu, du, dov, flt, bt;
  int seed = 32'h2dcf1e1f, mismatches = 0, checks_done = 0, code;
  always #5 clk = ~clk;
  rofs_top dut_u (
    .clk(clk), .resetn(resetn), .func_sel(func_sel),
    .bypass_overload_level(bypass_overload_level), .bypass_overload_limit(bypass_overload_limit),
    .bypass_underload_level(bypass_underload_level), .bypass_underload_limit(bypass_underload_limit),
    .drive_overload_level(drive_overload_level), .drive_overload_limit(drive_overload_limit),
    .drive_underload_level(drive_underload_level), .drive_underload_limit(drive_underload_limit),
    .board_temp(board_temp), .drive_fault(drive_fault), .bypass_fault(bypass_fault),
    .drive_warning(drive_warning), .bypass_warning(bypass_warning), .bypass_selected(bypass_selected),
    .drive_auto(drive_auto), .bypass_auto(bypass_auto), .drive_contactor_fault(drive_contactor_fault),
    .bypass_contactor_fault(bypass_contactor_fault), .drive_contactor_closed(drive_contactor_closed),
    .internal_link_lost(internal_link_lost), .network_link_lost(network_link_lost),
    .override_two_active(override_two_active), .override_two_action_stop(override_two_action_stop),
    .interlock_ack_cfg(interlock_ack_cfg), .interlock_present(interlock_present),
    .relay_coil(relay_coil), .condition_status(condition_status)
  );
  rofs_relay_load load_u (.coil(relay_coil), .contact(contact));
  task automatic check(input logic [13:0] seen, input logic [13:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic test_done();
    $display("counts %0d checks %0d mismatches", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic stim(input int t);
    int r;
    r = $random(seed);
    {drive_fault, bypass_fault, drive_warning, bypass_warning, bypass_selected, drive_auto, bypass_auto,
      drive_contactor_fault, bypass_contactor_fault, drive_contactor_closed, internal_link_lost,
      network_link_lost, override_two_active, override_two_action_stop} = r[13:0];
    {interlock_ack_cfg, interlock_present} = r[25:14];
    {bypass_overload_level, bypass_overload_limit} = $random(seed);
    {bypass_underload_level, bypass_underload_limit} = $random(seed);
    {drive_overload_level, drive_overload_limit} = $random(seed);
    {drive_underload_level, drive_underload_limit} = $random(seed);
    board_temp = TEMP_LIMIT + 8'(t % 3) - 8'h1;
    for (int i = 0; i < 5; i++) func_sel[i*6 +: 6] = 6'((t * 5 + i) % 16 + 18);
  endtask
  initial begin
    stim(0);
    repeat (6) @(negedge clk);
    resetn = 1;
    for (int t = 0; t < 48; t++) begin
      @(negedge clk);
      stim(t);
      repeat (5) @(negedge clk);
      bo = bypass_overload_level > bypass_overload_limit;
      bu = bypass_underload_level < bypass_underload_limit;
      dov = drive_overload_level > drive_overload_limit;
      du = drive_underload_level < drive_underload_limit;
      flt = drive_fault | bypass_fault;
      bt = bo | bu;
      exp = {drive_contactor_closed & (&(interlock_present | ~interlock_ack_cfg)),
        override_two_active & override_two_action_stop, network_link_lost, internal_link_lost,
        ~(flt | (bypass_selected ? bt : dov | du)), drive_contactor_fault | bypass_contactor_fault, bo | dov,
        bypass_selected ? bypass_auto : drive_auto, flt | bt | drive_warning | bypass_warning, flt | bt, bu | du,
        board_temp > TEMP_LIMIT, bu, bo};
      check(condition_status, exp);
      for (int i = 0; i < 5; i++) begin
        code = func_sel[i*6 +: 6];
        check(14'(contact[i]), (code > 18 && code < 33) ? 14'(exp[code-19]) : 14'h0);
      end
    end
    $display("test steady_functions done");
    resetn = 0;
    @(negedge clk);
    check(condition_status, 14'h0);
    check(14'(relay_coil), 14'h0);
    $display("test mid_reset done");
    test_done();
  end
  initial begin
    #100000;
    mismatches++;
    test_done();
  end
endmodule // relay_output_function_select_tb
bind rofs_top rofs_top_assertions #(.RELAYS(RELAYS)) chk_u (
  .clk(clk), .resetn(resetn), .func_sel(func_sel),
  .bypass_overload_level(bypass_overload_level), .bypass_overload_limit(bypass_overload_limit),
  .board_temp(board_temp), .internal_link_lost(internal_link_lost), .network_link_lost(network_link_lost),
  .override_two_active(override_two_active), .override_two_action_stop(override_two_action_stop),
  .drive_contactor_fault(drive_contactor_fault), .bypass_contactor_fault(bypass_contactor_fault),
  .relay_coil(relay_coil), .condition_status(condition_status)
);
